// ---- host_port_sleep_permit.sv ----
// Sleep-permit logic for the LPC host port, with its Wishbone register slave
`timescale 1ns/1ns

// Summary of operation
// R1: Software must always write one into test bit 2 of the control register.
// R2: Read/write two-bit policy field at bits 1:0 picks the sleep permit condition.
// R3: Policy 3 withholds sleep permission while the host interface is active.
// R4: Activation bit low always permits sleep; policy only matters when it is one.
// R5: Policy 2 permits sleep once each LPC transaction has completed.
// R6: Policy 1 permits sleep on clock stop with no serial IRQ or DMA pending.
// R7: Clock stop is seen when CLKRUN# stays high five link clocks after rising.
// R8: Policy 0 permits sleep whenever the LPC power-down input is driven low.
// R9: One registered permit output, high only while the selected condition holds.
module host_port_sleep_permit (
    // Core clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Link side, on the LPC bus clock
    input  wire logic        lpc_bus_clock_i,
    input  wire logic        clkrun_n_i,
    input  wire logic        lpc_txn_busy_i,
    // Core side request sources and power-down pin
    input  wire logic        serirq_pending_i,
    input  wire logic        dma_pending_i,
    input  wire logic        lpcpd_n_i,
    // Permit to the chip power manager
    output logic             sleep_permit_o
);

    // Register state
    host_port_sleep_permit_pkg::gating_ctrl_t ctrl_q;
    logic                                     activate_q;
    logic                                     ack_q;
    logic [31:0]                              rdata_q;
    logic                                     permit_q;
    logic                                     permit_d;

    // Link domain state
    logic                                     link_rst_meta_q;
    logic                                     link_rst_q;
    logic                                     clkrun_meta_q;
    logic                                     clkrun_sync_q;
    logic                                     clkrun_prev_q;
    host_port_sleep_permit_pkg::stop_state_t  stop_state_q;
    logic [2:0]                               stop_cnt_q;
    host_port_sleep_permit_pkg::link_status_t link_stat_q;

    // Crossing and pin synchronisers in the core domain
    host_port_sleep_permit_pkg::link_status_t stat_meta_q;
    host_port_sleep_permit_pkg::link_status_t stat_sync_q;
    logic                                     lpcpd_meta_q;
    logic                                     lpcpd_sync_q;

    // Bus decode
    logic                                     bus_req;
    logic                                     wr_commit;
    logic                                     clkrun_rise;

    // Word match of a byte address against a register offset
    function automatic logic hits(input logic [11:0] adr, input logic [11:0] off);
        hits = (adr[11:2] == off[11:2]);
    endfunction

    // Request and commit strobes; a write lands on the edge the master sees ack
    assign bus_req   = wb_cyc_i & wb_stb_i;
    assign wr_commit = bus_req & wb_we_i & ack_q & wb_sel_i[0];

    // Ack pulses once per request and drops in the following cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    assign wb_ack_o = ack_q;

    // Policy field and test bit; the test bit is stored as software writes it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q.test   <= host_port_sleep_permit_pkg::TEST_RESET;
            ctrl_q.policy <= host_port_sleep_permit_pkg::policy_t'(
                host_port_sleep_permit_pkg::POLICY_RESET);
        end else if (wr_commit && hits(wb_adr_i, host_port_sleep_permit_pkg::GATING_CTRL_OFFSET)) begin
            ctrl_q.test   <= wb_dat_i[host_port_sleep_permit_pkg::TEST_BIT];
            ctrl_q.policy <= host_port_sleep_permit_pkg::policy_t'(
                wb_dat_i[host_port_sleep_permit_pkg::POLICY_MSB:
                         host_port_sleep_permit_pkg::POLICY_LSB]); // R2
        end
    end

    // Host interface activation bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            activate_q <= host_port_sleep_permit_pkg::ACTIVATE_RESET;
        end else if (wr_commit && hits(wb_adr_i, host_port_sleep_permit_pkg::ACTIVATE_OFFSET)) begin
            activate_q <= wb_dat_i[host_port_sleep_permit_pkg::ACTIVATE_BIT];
        end
    end

    // Read data is latched with ack; unmapped words read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= host_port_sleep_permit_pkg::DATA_RESET;
        end else if (bus_req && !ack_q) begin
            rdata_q <= host_port_sleep_permit_pkg::DATA_RESET;
            if (hits(wb_adr_i, host_port_sleep_permit_pkg::GATING_CTRL_OFFSET)) begin
                rdata_q[host_port_sleep_permit_pkg::TEST_BIT] <= ctrl_q.test;
                rdata_q[host_port_sleep_permit_pkg::POLICY_MSB:
                        host_port_sleep_permit_pkg::POLICY_LSB] <= ctrl_q.policy; // R2
            end
            if (hits(wb_adr_i, host_port_sleep_permit_pkg::ACTIVATE_OFFSET)) begin
                rdata_q[host_port_sleep_permit_pkg::ACTIVATE_BIT] <= activate_q;
            end
            if (hits(wb_adr_i, host_port_sleep_permit_pkg::STATUS_OFFSET)) begin
                rdata_q[host_port_sleep_permit_pkg::STAT_PERMIT_BIT]   <= permit_q;
                rdata_q[host_port_sleep_permit_pkg::STAT_CLK_STOP_BIT] <= stat_sync_q.clk_stop;
                rdata_q[host_port_sleep_permit_pkg::STAT_TXN_BUSY_BIT] <= stat_sync_q.txn_busy;
                rdata_q[host_port_sleep_permit_pkg::STAT_LPCPD_BIT]    <= ~lpcpd_sync_q;
            end
        end
    end

    assign wb_dat_o = rdata_q;

    // ------------------------------------------------------------------
    // Link domain, clocked by the LPC bus clock
    // ------------------------------------------------------------------

    // System reset brought into the link domain; the link clock may be stopped
    // while reset is applied, so the release is only seen once it runs again
    always_ff @(posedge lpc_bus_clock_i) begin
        link_rst_meta_q <= rst_i;
        link_rst_q      <= link_rst_meta_q;
    end

    // CLKRUN# pin synchroniser; only the second stage and its delayed copy feed logic
    always_ff @(posedge lpc_bus_clock_i) begin
        if (link_rst_q) begin
            clkrun_meta_q <= 1'b0;
            clkrun_sync_q <= 1'b0;
            clkrun_prev_q <= 1'b0;
        end else begin
            clkrun_meta_q <= clkrun_n_i;
            clkrun_sync_q <= clkrun_meta_q;
            clkrun_prev_q <= clkrun_sync_q;
        end
    end

    assign clkrun_rise = clkrun_sync_q & ~clkrun_prev_q;

    // Clock-stop detector: the rising edge counts as the first high period
    always_ff @(posedge lpc_bus_clock_i) begin
        if (link_rst_q) begin
            stop_state_q <= host_port_sleep_permit_pkg::STOP_WATCH;
            stop_cnt_q   <= 3'h0;
        end else begin
            case (stop_state_q)
                host_port_sleep_permit_pkg::STOP_WATCH: begin
                    if (clkrun_rise) begin
                        stop_state_q <= host_port_sleep_permit_pkg::STOP_COUNT;
                        stop_cnt_q   <= 3'h1;
                    end
                end
                host_port_sleep_permit_pkg::STOP_COUNT: begin
                    if (!clkrun_sync_q) begin
                        stop_state_q <= host_port_sleep_permit_pkg::STOP_WATCH;
                        stop_cnt_q   <= 3'h0;
                    end else if (stop_cnt_q ==
                                 host_port_sleep_permit_pkg::CLK_STOP_LPC_CYCLES - 3'h1) begin
                        stop_state_q <= host_port_sleep_permit_pkg::STOP_SEEN; // R7
                        stop_cnt_q   <= host_port_sleep_permit_pkg::CLK_STOP_LPC_CYCLES;
                    end else begin
                        stop_cnt_q <= stop_cnt_q + 3'h1;
                    end
                end
                host_port_sleep_permit_pkg::STOP_SEEN: begin
                    // Held while the clock is stopped; dropped once CLKRUN# falls
                    if (!clkrun_sync_q) begin
                        stop_state_q <= host_port_sleep_permit_pkg::STOP_WATCH;
                        stop_cnt_q   <= 3'h0;
                    end
                end
                default: begin
                    stop_state_q <= host_port_sleep_permit_pkg::STOP_WATCH;
                    stop_cnt_q   <= 3'h0;
                end
            endcase
        end
    end

    // Link status levels registered before they cross
    always_ff @(posedge lpc_bus_clock_i) begin
        if (link_rst_q) begin
            link_stat_q <= '0;
        end else begin
            link_stat_q.clk_stop <= (stop_state_q == host_port_sleep_permit_pkg::STOP_SEEN); // R7
            link_stat_q.txn_busy <= lpc_txn_busy_i;
        end
    end

    // ------------------------------------------------------------------
    // Core domain permit decision
    // ------------------------------------------------------------------

    // Two-flop crossing of the link levels; each bit is an independent level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_meta_q <= '0;
            stat_sync_q <= '0;
        end else begin
            stat_meta_q <= link_stat_q;
            stat_sync_q <= stat_meta_q;
        end
    end

    // Power-down pin synchroniser; reset to the deasserted level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lpcpd_meta_q <= 1'b1;
            lpcpd_sync_q <= 1'b1;
        end else begin
            lpcpd_meta_q <= lpcpd_n_i;
            lpcpd_sync_q <= lpcpd_meta_q;
        end
    end

    // Condition selected by the policy; activation low overrides the field
    always_comb begin
        permit_d = 1'b0;
        if (!activate_q) begin
            permit_d = 1'b1; // R4
        end else begin
            case (ctrl_q.policy)
                host_port_sleep_permit_pkg::POLICY_NEVER: begin
                    permit_d = 1'b0; // R3
                end
                host_port_sleep_permit_pkg::POLICY_PER_TXN: begin
                    // Waking for the next cycle costs oscillator restart latency
                    permit_d = ~stat_sync_q.txn_busy; // R5
                end
                host_port_sleep_permit_pkg::POLICY_CLKRUN: begin
                    permit_d = stat_sync_q.clk_stop & ~serirq_pending_i & ~dma_pending_i; // R6
                end
                host_port_sleep_permit_pkg::POLICY_LPCPD: begin
                    permit_d = ~lpcpd_sync_q; // R8
                end
                default: begin
                    permit_d = 1'b0;
                end
            endcase
        end
    end

    // Registered permit follows the condition one cycle later, both ways
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            permit_q <= 1'b0;
        end else begin
            permit_q <= permit_d; // R9
        end
    end

    assign sleep_permit_o = permit_q;

endmodule

// ---- host_port_sleep_permit_pkg.sv ----
// Constants and types for the host port sleep-permit block
package host_port_sleep_permit_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [11:0] GATING_CTRL_OFFSET = 12'h110;
    localparam logic [11:0] ACTIVATE_OFFSET    = 12'h11c;
    localparam logic [11:0] STATUS_OFFSET      = 12'h1f0;

    // Field positions in the gating control register
    localparam int unsigned POLICY_LSB = 0;
    localparam int unsigned POLICY_MSB = 1;
    localparam int unsigned TEST_BIT   = 2;

    // Field positions in the activation register
    localparam int unsigned ACTIVATE_BIT = 0;

    // Field positions in the status register
    localparam int unsigned STAT_PERMIT_BIT   = 0;
    localparam int unsigned STAT_CLK_STOP_BIT = 1;
    localparam int unsigned STAT_TXN_BUSY_BIT = 2;
    localparam int unsigned STAT_LPCPD_BIT    = 3;

    // Values after reset
    localparam logic [1:0]  POLICY_RESET   = 2'h0;
    localparam logic        TEST_RESET     = 1'h1;
    localparam logic        ACTIVATE_RESET = 1'h0;
    localparam logic [31:0] DATA_RESET     = 32'h0000_0000;

    // Link clock periods CLKRUN# must stay high after its rising edge
    localparam logic [2:0] CLK_STOP_LPC_CYCLES = 3'h5;

    // Gating policy encodings
    typedef enum logic [1:0] {
        POLICY_LPCPD   = 2'h0,
        POLICY_CLKRUN  = 2'h1,
        POLICY_PER_TXN = 2'h2,
        POLICY_NEVER   = 2'h3
    } policy_t;

    // Gating control register contents
    typedef struct packed {
        logic    test;
        policy_t policy;
    } gating_ctrl_t;

    // Levels that leave the link domain
    typedef struct packed {
        logic clk_stop;
        logic txn_busy;
    } link_status_t;

    // Clock-stop detector states
    typedef enum logic [2:0] {
        STOP_WATCH = 3'b001,
        STOP_COUNT = 3'b010,
        STOP_SEEN  = 3'b100
    } stop_state_t;

endpackage

// ---- host_port_sleep_permit_sva.sv ----
// Assertion checker for the host port sleep-permit block
`timescale 1ns/1ns
module host_port_sleep_permit_sva (
    // Core clock, reset and register bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Link side, pins and permit
    input wire logic        lpc_bus_clock_i,
    input wire logic        clkrun_n_i,
    input wire logic        lpc_txn_busy_i,
    input wire logic        serirq_pending_i,
    input wire logic        dma_pending_i,
    input wire logic        lpcpd_n_i,
    input wire logic        sleep_permit_o
);
    localparam logic [11:0] CTRL = host_port_sleep_permit_pkg::GATING_CTRL_OFFSET;
    localparam logic [11:0] ACT  = host_port_sleep_permit_pkg::ACTIVATE_OFFSET;
    logic [2:0] ctl_q;
    logic       act_q;
    logic [7:0] quiet_q;
    logic [2:0] pins_q;
    logic [2:0] pins;
    logic [2:0] mode;
    logic       wr;
    logic       settled;

    assign pins = {clkrun_n_i, lpc_txn_busy_i, lpcpd_n_i};
    // A level that moves at this very edge is not yet in the count, so check it too
    assign settled = (quiet_q >= 8'hc8) && (pins == pins_q);
    assign mode = {act_q, ctl_q[1:0]};
    assign wr   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];

    // Shadow fields commit on the edge where the master sees ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q <= 3'h4;
            act_q <= 1'h0;
        end else if (wr && wb_adr_i[11:2] == CTRL[11:2]) begin
            ctl_q <= wb_dat_i[2:0];
        end else if (wr && wb_adr_i[11:2] == ACT[11:2]) begin
            act_q <= wb_dat_i[0];
        end
    end

    // Cycles since a link or pin level moved; sync paths settle long before 200
    always_ff @(posedge clk_i) begin
        pins_q <= pins;
        if (rst_i || pins != pins_q) begin
            quiet_q <= 8'h0;
        end else if (quiet_q != 8'hff) begin
            quiet_q <= quiet_q + 8'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ctrl_read;
        wb_ack_o && !wb_we_i && wb_adr_i[11:2] == CTRL[11:2] |-> wb_dat_o == {29'h0, ctl_q};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
    property p_never; $past(mode) == 3'h7 |-> !sleep_permit_o; endproperty
    a_never: assert property (p_never) else $error("permit under policy 3");
    property p_idle; !$past(act_q) && !$past(rst_i) |-> sleep_permit_o; endproperty
    a_idle: assert property (p_idle) else $error("permit missing while inactive");
    property p_per_txn; $past(mode) == 3'h6 && settled |-> sleep_permit_o == !lpc_txn_busy_i;
    endproperty
    a_per_txn: assert property (p_per_txn) else $error("policy 2 permit wrong");
    property p_clk_stop;
        $past(mode) == 3'h5 && settled |->
            sleep_permit_o == (clkrun_n_i && !$past(serirq_pending_i) && !$past(dma_pending_i));
    endproperty
    a_clk_stop: assert property (p_clk_stop) else $error("policy 1 permit wrong");
    property p_stop_len;
        $rose(sleep_permit_o) && $past(mode) == 3'h5 |-> clkrun_n_i && quiet_q >= 8'h50;
    endproperty
    a_stop_len: assert property (p_stop_len) else $error("clock stop seen too early");
    property p_pd; $past(mode) == 3'h4 && settled |-> sleep_permit_o == !lpcpd_n_i;
    endproperty
    a_pd: assert property (p_pd) else $error("policy 0 permit wrong");
    property p_prompt; $fell(act_q) |=> sleep_permit_o; endproperty
    a_prompt: assert property (p_prompt) else $error("permit late after deactivation");
endmodule

bind host_port_sleep_permit host_port_sleep_permit_sva u_sva (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .lpc_bus_clock_i, .clkrun_n_i, .lpc_txn_busy_i,
    .serirq_pending_i, .dma_pending_i, .lpcpd_n_i, .sleep_permit_o);

// ---- host_port_sleep_permit_tb_top.sv ----
// Self-checking testbench for the host port sleep-permit block
`timescale 1ns/1ns
module host_port_sleep_permit_tb_top;
    localparam logic [11:0] CTRL = host_port_sleep_permit_pkg::GATING_CTRL_OFFSET;
    localparam logic [11:0] ACT  = host_port_sleep_permit_pkg::ACTIVATE_OFFSET;
    localparam logic [11:0] STAT = host_port_sleep_permit_pkg::STATUS_OFFSET;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        lpc_bus_clock_i;
    logic        clkrun_n_i;
    logic        lpc_txn_busy_i;
    logic        serirq_pending_i = 1'b0;
    logic        dma_pending_i = 1'b0;
    logic        lpcpd_n_i = 1'b1;
    logic        sleep_permit_o;
    int          fail_count = 0;
    int          checks = 0;

    always #5 clk_i = ~clk_i;

    lpc_host_model host (.lpc_bus_clock_o(lpc_bus_clock_i), .clkrun_n_o(clkrun_n_i),
        .txn_busy_o(lpc_txn_busy_i));
    host_port_sleep_permit dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .lpc_bus_clock_i, .clkrun_n_i,
        .lpc_txn_busy_i, .serirq_pending_i, .dma_pending_i, .lpcpd_n_i, .sleep_permit_o);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Request stands until ack is sampled high at a rising edge; data is taken there.
    // Only the watchdog ends a wait, so a silent slave shows up as a timeout.
    task automatic access(input logic we, input logic [11:0] adr, input logic [31:0] dat,
                          output logic [31:0] rdat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        // Ack must be gone in the cycle after it was given
        @(posedge clk_i);
        check({31'h0, wb_ack_o}, 32'h0);
    endtask

    task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
        logic [31:0] rdat;
        access(1'b1, adr, dat, rdat);
    endtask

    task automatic rd(input logic [11:0] adr, input logic [31:0] exp);
        logic [31:0] rdat;
        access(1'b0, adr, 32'h0, rdat);
        check(rdat, exp);
    endtask

    // Span covers sync stages and, where needed, link clock periods
    task automatic perm(input logic exp, input int span);
        repeat (span) @(posedge clk_i);
        @(negedge clk_i);
        check({31'h0, sleep_permit_o}, {31'h0, exp});
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Reset lasts ten core clocks; the link domain clears on the link edges that
    // follow, so its status levels are only read after a settling wait
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CTRL, 32'h4);
        rd(ACT, 32'h0);
        repeat (40) @(posedge clk_i);
        rd(STAT, 32'h1);
        wr(12'h200, 32'hffff_ffff);
        rd(12'h200, 32'h0);
        for (int p = 0; p < 4; p++) begin
            wr(CTRL, {29'h0, 1'b1, p[1:0]});
            rd(CTRL, {29'h0, 1'b1, p[1:0]});
        end
        perm(1'b1, 4);
        wr(ACT, 32'h1);
        perm(1'b0, 4);
        wr(ACT, 32'h0);
        perm(1'b1, 0);
        wr(ACT, 32'h1);
        $display("test registers done");
        wr(CTRL, 32'h4);
        perm(1'b0, 4);
        @(posedge clk_i);
        lpcpd_n_i <= 1'b0;
        perm(1'b1, 250);
        rd(STAT, 32'h9);
        @(posedge clk_i);
        lpcpd_n_i <= 1'b1;
        perm(1'b0, 4);
        $display("test power-down done");
        wr(CTRL, 32'h6);
        fork
            host.transfer(20);
            begin
                perm(1'b0, 220);
                rd(STAT, 32'h4);
            end
        join
        perm(1'b1, 30);
        $display("test per transaction done");
        wr(CTRL, 32'h5);
        perm(1'b0, 4);
        host.stop_clock(3, 1'b0);
        perm(1'b0, 60);
        host.stop_clock(10, 1'b1);
        perm(1'b1, 250);
        rd(STAT, 32'h3);
        @(posedge clk_i);
        serirq_pending_i <= 1'b1;
        perm(1'b0, 2);
        @(posedge clk_i);
        serirq_pending_i <= 1'b0;
        dma_pending_i <= 1'b1;
        perm(1'b0, 2);
        @(posedge clk_i);
        dma_pending_i <= 1'b0;
        perm(1'b1, 2);
        host.restart();
        perm(1'b0, 40);
        $display("test clock stop done");
        close_out();
    end

    // The run needs far less than this span
    initial begin
        #200000;
        fail_count++;
        close_out();
    end
endmodule

// ---- lpc_host_model.sv ----
// Behavioural LPC host: link clock, CLKRUN# and transaction activity
`timescale 1ns/1ns
module lpc_host_model (
    // Link signals toward the block
    output logic lpc_bus_clock_o = 1'b0,
    output logic clkrun_n_o      = 1'b0,
    output logic txn_busy_o      = 1'b0
);
    logic run_q = 1'b1;

    // Phase is free against the core clock; the clock stands still once stopped
    always begin
        #80;
        if (run_q) begin
            lpc_bus_clock_o = ~lpc_bus_clock_o;
        end
    end

    // One transaction lasting the given number of link clocks
    task automatic transfer(input int len);
        @(posedge lpc_bus_clock_o);
        txn_busy_o <= 1'b1;
        repeat (len) @(posedge lpc_bus_clock_o);
        txn_busy_o <= 1'b0;
    endtask

    // CLKRUN# high for len clocks, then either halt the clock or pull it low
    task automatic stop_clock(input int len, input bit halt);
        @(posedge lpc_bus_clock_o);
        clkrun_n_o <= 1'b1;
        repeat (len) @(posedge lpc_bus_clock_o);
        if (halt) begin
            run_q = 1'b0;
        end else begin
            clkrun_n_o <= 1'b0;
        end
    endtask

    // Resume the clock first so the block sees CLKRUN# low on a real edge
    task automatic restart();
        run_q = 1'b1;
        @(posedge lpc_bus_clock_o);
        clkrun_n_o <= 1'b0;
        repeat (4) @(posedge lpc_bus_clock_o);
    endtask
endmodule
